// >>> rzh_pkg.sv
package rzh_pkg;

    localparam logic [7:0] REG_CONTROL    = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_CMD        = 8'h08;
    localparam logic [7:0] REG_POSITION   = 8'h0c;
    localparam logic [7:0] REG_TARGET     = 8'h10;
    localparam logic [7:0] REG_LIMIT_POS  = 8'h14;
    localparam logic [7:0] REG_LIMIT_NEG  = 8'h18;
    localparam logic [7:0] REG_START_SPD  = 8'h1c;
    localparam logic [7:0] REG_RUN_SPD    = 8'h20;
    localparam logic [7:0] REG_ACCEL      = 8'h24;
    localparam logic [7:0] REG_DECEL      = 8'h28;
    localparam logic [7:0] REG_COND       = 8'h2c;

    localparam int CTRL_LIMIT_EN  = 0;
    localparam int CTRL_SOFT_LIMIT_POSITIVE_SET  = 1;
    localparam int CTRL_SOFT_LIMIT_NEGATIVE_SET  = 2;

    localparam int ST_MOVING      = 0;
    localparam int ST_HOME_VALID  = 1;
    localparam int ST_CHECK_ON    = 2;
    localparam int ST_LIMIT_POS   = 3;
    localparam int ST_LIMIT_NEG   = 4;
    localparam int ST_REJECTED    = 5;
    localparam int ST_ELSE_TAKEN  = 6;
    localparam int ST_MOVE_DONE   = 7;

    localparam logic [3:0] CMD_NONE        = 4'h0;
    localparam logic [3:0] CMD_RETURN_ZERO = 4'h1;
    localparam logic [3:0] CMD_ABS_GOTO    = 4'h2;
    localparam logic [3:0] CMD_SEEK_POS    = 4'h3;
    localparam logic [3:0] CMD_SEEK_NEG    = 4'h4;
    localparam logic [3:0] CMD_STOP        = 4'h5;
    localparam logic [3:0] CMD_IF          = 4'h6;
    localparam logic [3:0] CMD_ELSE        = 4'h7;
    localparam logic [3:0] CMD_ENDIF       = 4'h8;

    localparam logic [31:0] ZERO_POSITION  = 32'h0000_0000;
    localparam logic [31:0] RST_START_SPD  = 32'h0000_0001;
    localparam logic [31:0] RST_RUN_SPD    = 32'h0000_0004;
    localparam logic [31:0] RST_RAMP       = 32'h0000_0010;
    localparam logic [15:0] RATE_ONE       = 16'h0001;

    typedef enum logic [1:0] {
        RZH_IDLE  = 2'b00,
        RZH_RUN   = 2'b01,
        RZH_SEEK  = 2'b10
    } rzh_state_t;

    typedef enum logic [1:0] {
        RZH_PH_ACCEL = 2'b00,
        RZH_PH_CRUISE = 2'b01,
        RZH_PH_DECEL = 2'b10
    } rzh_phase_t;

endpackage

// >>> rzh_profile.sv
`timescale 1ns/1ns
// Trapezoid speed generator: ramps from start speed to run speed and back down.
module rzh_profile
    import rzh_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic [31:0] distance,
    input  wire logic [31:0] start_stop_speed,
    input  wire logic [31:0] run_speed,
    input  wire logic [31:0] accel_time,
    input  wire logic [31:0] decel_time,
    output logic             busy,
    output logic      [31:0] step
);

    rzh_phase_t  phase;
    logic [31:0] speed;
    logic [31:0] remaining;
    logic [31:0] ramp_cnt;
    logic [31:0] travelled;

    wire logic [31:0] clipped_step = (speed > remaining) ? remaining : speed;
    wire logic        at_end       = (remaining == clipped_step);
    wire logic        need_decel   = (remaining <= travelled);
    wire logic [31:0] acc_slope    = (accel_time == 32'h0) ? run_speed : 32'h1;
    wire logic [31:0] dec_slope    = (decel_time == 32'h0) ? run_speed : 32'h1;

    // Speed never drops under the start/stop speed, so the move always ends while that speed is non-zero.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            busy      <= 1'b0;
            phase     <= RZH_PH_ACCEL;
            speed     <= 32'h0;
            remaining <= 32'h0;
            ramp_cnt  <= 32'h0;
            travelled <= 32'h0;
            step      <= 32'h0;
        end else if (abort) begin
            busy <= 1'b0;
            step <= 32'h0;
        end else if (start) begin
            busy      <= (distance != 32'h0);
            phase     <= RZH_PH_ACCEL;
            speed     <= start_stop_speed;
            remaining <= distance;
            ramp_cnt  <= 32'h0;
            travelled <= 32'h0;
            step      <= 32'h0;
        end else if (busy) begin
            step      <= clipped_step;
            remaining <= remaining - clipped_step;
            travelled <= travelled + clipped_step;
            busy      <= !at_end;
            ramp_cnt  <= ramp_cnt + 32'h1;
            case (phase)
                RZH_PH_ACCEL: begin
                    if (need_decel) begin
                        phase <= RZH_PH_DECEL;
                    end else if (speed >= run_speed) begin
                        phase <= RZH_PH_CRUISE;
                    end else if (ramp_cnt >= accel_time) begin
                        speed    <= speed + acc_slope;
                        ramp_cnt <= 32'h0;
                    end
                end
                RZH_PH_CRUISE: begin
                    if (need_decel) begin
                        phase <= RZH_PH_DECEL;
                    end
                end
                RZH_PH_DECEL: begin
                    if (ramp_cnt >= decel_time && speed > start_stop_speed) begin
                        speed    <= (speed < start_stop_speed + dec_slope) ?
                                    start_stop_speed : speed - dec_slope;
                        ramp_cnt <= 32'h0;
                    end
                end
                default: phase <= RZH_PH_ACCEL;
            endcase
        end else begin
            step <= 32'h0;
        end
    end

endmodule

// >>> rzh_top.sv
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
module rzh_top
    import rzh_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        home_sensor,
    input  wire logic        limit_sensor_pos,
    input  wire logic        limit_sensor_neg,
    output logic             motion_in_progress,
    output logic             step_dir,
    output logic      [31:0] step_count
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [31:0] control;
    logic [31:0] commanded_position;
    logic [31:0] target;
    logic [31:0] soft_limit_positive;
    logic [31:0] soft_limit_negative;
    logic [31:0] start_stop_speed;
    logic [31:0] run_speed;
    logic [31:0] accel_time;
    logic [31:0] decel_time;
    logic        home_valid;
    logic        cmd_rejected;
    logic        move_done;
    logic        cond_false;
    logic        in_else;
    logic        in_if;
    logic        rd_pending;
    rzh_state_t  state;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode. Writes finish in one cycle; reads take one wait cycle.

    wire logic        wr_ctrl   = avs_write && avs_address == REG_CONTROL;
    wire logic        wr_cmd    = avs_write && avs_address == REG_CMD && avs_byteenable[0];
    wire logic        wr_pos    = avs_write && avs_address == REG_POSITION;
    wire logic        wr_target = avs_write && avs_address == REG_TARGET;
    wire logic        wr_soft_limit_positive   = avs_write && avs_address == REG_LIMIT_POS;
    wire logic        wr_soft_limit_negative   = avs_write && avs_address == REG_LIMIT_NEG;
    wire logic        wr_vs     = avs_write && avs_address == REG_START_SPD;
    wire logic        wr_vr     = avs_write && avs_address == REG_RUN_SPD;
    wire logic        wr_ta     = avs_write && avs_address == REG_ACCEL;
    wire logic        wr_td     = avs_write && avs_address == REG_DECEL;
    wire logic        wr_cond   = avs_write && avs_address == REG_COND;
    wire logic [3:0]  cmd_code  = avs_writedata[3:0];

    assign avs_waitrequest = avs_read && !rd_pending;

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode and acceptance.

    wire logic is_motion_cmd = (cmd_code == CMD_RETURN_ZERO) || (cmd_code == CMD_ABS_GOTO) ||
                               (cmd_code == CMD_SEEK_POS) || (cmd_code == CMD_SEEK_NEG);
    // Inside the alternate block commands run only if the condition was false.
    wire logic block_skip    = (in_if && !in_else && cond_false) ||
                               (in_if && in_else && !cond_false);
    wire logic skip_cmd      = block_skip && cmd_code != CMD_ELSE && cmd_code != CMD_ENDIF;
    wire logic busy_axis     = motion_in_progress;
    wire logic motion_refuse = wr_cmd && is_motion_cmd && busy_axis && !skip_cmd;
    wire logic motion_go     = wr_cmd && is_motion_cmd && !busy_axis && !skip_cmd;
    wire logic go_zero       = motion_go && cmd_code == CMD_RETURN_ZERO;
    wire logic go_abs        = motion_go && cmd_code == CMD_ABS_GOTO;
    wire logic go_seek       = motion_go && (cmd_code == CMD_SEEK_POS || cmd_code == CMD_SEEK_NEG);
    wire logic stop_now      = wr_cmd && cmd_code == CMD_STOP && !skip_cmd;

    // Return-to-zero behaves as an absolute goto with target zero.
    wire logic [31:0] move_target = go_zero ? ZERO_POSITION : target;
    wire logic        move_up     = $signed(move_target) >= $signed(commanded_position);
    wire logic [31:0] move_dist   = move_up ? move_target - commanded_position
                                            : commanded_position - move_target;
    wire logic        seek_up     = cmd_code == CMD_SEEK_POS;

    ////////////////////////////////////////////////////////////////////////////////
    // Motion profile.

    logic        prof_busy;
    logic [31:0] prof_step;
    logic        seek_hit;

    wire logic prof_start = go_zero || go_abs;
    // A soft limit stop also ends the profile, so no stale steps are left running.
    wire logic prof_abort = stop_now || seek_hit || (state == RZH_RUN && limit_hit);

    rzh_profile u_profile (
        .ref_clk          (ref_clk),
        .reset            (reset),
        .start            (prof_start),
        .abort            (prof_abort),
        .distance         (move_dist),
        .start_stop_speed (start_stop_speed),
        .run_speed        (run_speed),
        .accel_time       (accel_time),
        .decel_time       (decel_time),
        .busy             (prof_busy),
        .step             (prof_step)
    );

    wire logic [31:0] seek_step = start_stop_speed;
    assign seek_hit = (state == RZH_SEEK) &&
                      (home_sensor || (step_dir ? limit_sensor_pos : limit_sensor_neg));
    wire logic [31:0] active_step = (state == RZH_SEEK) ? seek_step : prof_step;
    wire logic [31:0] next_position = step_dir ? commanded_position + active_step
                                               : commanded_position - active_step;

    ////////////////////////////////////////////////////////////////////////////////
    // Soft limit checking.

    wire logic check_on  = control[CTRL_LIMIT_EN] && control[CTRL_SOFT_LIMIT_POSITIVE_SET] &&
                           control[CTRL_SOFT_LIMIT_NEGATIVE_SET] && home_valid;
    wire logic over_pos  = check_on &&
                           $signed(commanded_position) >= $signed(soft_limit_positive);
    wire logic over_neg  = check_on &&
                           $signed(commanded_position) <= $signed(soft_limit_negative);
    wire logic limit_hit = (over_pos && step_dir) || (over_neg && !step_dir);

    ////////////////////////////////////////////////////////////////////////////////
    // Axis state.

    rzh_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            RZH_IDLE: begin
                if (prof_start) begin
                    next_state = RZH_RUN;
                end else if (go_seek) begin
                    next_state = RZH_SEEK;
                end
            end
            RZH_RUN: begin
                if (!prof_busy && !prof_start && state == RZH_RUN && step_count == 32'h0) begin
                    next_state = RZH_IDLE;
                end
                if (stop_now || limit_hit) begin
                    next_state = RZH_IDLE;
                end
            end
            RZH_SEEK: begin
                if (seek_hit || stop_now || limit_hit) begin
                    next_state = RZH_IDLE;
                end
            end
            default: next_state = RZH_IDLE;
        endcase
    end

    wire logic run_ends = (state != RZH_IDLE) && (next_state == RZH_IDLE);
    // The last profile step arrives in the same cycle the profile drops busy, so a run applies every
    // step it sees; the profile shows zero once it is idle.
    wire logic stepping = (state == RZH_RUN) || (state == RZH_SEEK && !seek_hit);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state              <= RZH_IDLE;
            motion_in_progress <= 1'b0;
            step_dir           <= 1'b1;
            step_count         <= 32'h0;
            commanded_position <= ZERO_POSITION;
        end else begin
            state              <= next_state;
            motion_in_progress <= (next_state != RZH_IDLE);
            if (prof_start) begin
                step_dir <= move_up;
            end else if (go_seek) begin
                step_dir <= seek_up;
            end
            step_count <= (stepping && !limit_hit && !stop_now) ? active_step : 32'h0;
            if (wr_pos && !busy_axis) begin
                commanded_position <= merge_bytes(commanded_position, avs_writedata,
                                                  avs_byteenable);
            end else if (seek_hit && home_sensor) begin
                commanded_position <= ZERO_POSITION;
            end else if (stepping && !limit_hit && !stop_now) begin
                commanded_position <= next_position;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration, home and status flags.

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            control             <= 32'h0;
            target              <= ZERO_POSITION;
            soft_limit_positive <= ZERO_POSITION;
            soft_limit_negative <= ZERO_POSITION;
            start_stop_speed    <= RST_START_SPD;
            run_speed           <= RST_RUN_SPD;
            accel_time          <= RST_RAMP;
            decel_time          <= RST_RAMP;
            home_valid          <= 1'b0;
            cmd_rejected        <= 1'b0;
            move_done           <= 1'b0;
            cond_false          <= 1'b0;
            in_if               <= 1'b0;
            in_else             <= 1'b0;
            rd_pending          <= 1'b0;
        end else begin
            rd_pending <= avs_read && !rd_pending;
            if (wr_ctrl)   control             <= merge_bytes(control, avs_writedata, avs_byteenable);
            if (wr_target) target              <= merge_bytes(target, avs_writedata, avs_byteenable);
            if (wr_soft_limit_positive)   soft_limit_positive <= merge_bytes(soft_limit_positive, avs_writedata,
                                                              avs_byteenable);
            if (wr_soft_limit_negative)   soft_limit_negative <= merge_bytes(soft_limit_negative, avs_writedata,
                                                              avs_byteenable);
            if (wr_vs)     start_stop_speed    <= merge_bytes(start_stop_speed, avs_writedata,
                                                              avs_byteenable);
            if (wr_vr)     run_speed           <= merge_bytes(run_speed, avs_writedata,
                                                              avs_byteenable);
            if (wr_ta)     accel_time          <= merge_bytes(accel_time, avs_writedata,
                                                              avs_byteenable);
            if (wr_td)     decel_time          <= merge_bytes(decel_time, avs_writedata,
                                                              avs_byteenable);
            if (go_zero || (seek_hit && home_sensor)) begin
                home_valid <= 1'b1;
            end
            // A new refusal wins over a clear in the same write.
            if (motion_refuse) begin
                cmd_rejected <= 1'b1;
            end else if (wr_cmd && cmd_code == CMD_NONE) begin
                cmd_rejected <= 1'b0;
            end
            if (run_ends) begin
                move_done <= 1'b1;
            end else if (motion_go) begin
                move_done <= 1'b0;
            end
            if (wr_cond) begin
                cond_false <= !avs_writedata[0];
            end
            if (wr_cmd && cmd_code == CMD_IF) begin
                in_if   <= 1'b1;
                in_else <= 1'b0;
            end else if (wr_cmd && cmd_code == CMD_ELSE && in_if) begin
                in_else <= 1'b1;
            end else if (wr_cmd && cmd_code == CMD_ENDIF) begin
                in_if   <= 1'b0;
                in_else <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, registered on the wait cycle.

    wire logic [31:0] status_word = {24'h0, move_done, in_else && cond_false, cmd_rejected,
                                     over_neg, over_pos, check_on, home_valid,
                                     motion_in_progress};
    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address)
            REG_CONTROL:   rd_mux = {29'h0, control[2:0]};
            REG_STATUS:    rd_mux = status_word;
            REG_POSITION:  rd_mux = commanded_position;
            REG_TARGET:    rd_mux = target;
            REG_LIMIT_POS: rd_mux = soft_limit_positive;
            REG_LIMIT_NEG: rd_mux = soft_limit_negative;
            REG_START_SPD: rd_mux = start_stop_speed;
            REG_RUN_SPD:   rd_mux = run_speed;
            REG_ACCEL:     rd_mux = accel_time;
            REG_DECEL:     rd_mux = decel_time;
            REG_COND:      rd_mux = {31'h0, !cond_false};
            default:       rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !rd_pending) begin
            avs_readdata <= rd_mux;
        end
    end

endmodule

// >>> rzh_checker.sv
`timescale 1ns/1ns
module rzh_checker
    import rzh_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        motion_in_progress,
    input wire logic        step_dir,
    input wire logic [31:0] step_count
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire rz_cmd = avs_write && avs_address == REG_CMD && avs_byteenable[0]
                  && avs_writedata[3:0] == CMD_RETURN_ZERO;
    ////////////////////////////////////////////////////////////////////////////
    wr_nowait_a: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    rd_onewait_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read waited more than one cycle");
    wait_cause_a: assert property (avs_waitrequest |-> avs_read)
        else $error("wait without read");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'hfc
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    rz_start_a: assert property (rz_cmd && !motion_in_progress |=> motion_in_progress)
        else $error("return to zero did not start");
    rest_still_a: assert property (!motion_in_progress |-> step_count == 32'h0)
        else $error("steps while at rest");
    dir_steady_a: assert property (motion_in_progress && $past(motion_in_progress)
        |-> $stable(step_dir)) else $error("direction changed in a move");
    move_ends_a: assert property ($rose(motion_in_progress)
        |-> ##[1:1000] !motion_in_progress) else $error("move did not end");
endmodule
bind rzh_top rzh_checker i_rzh_checker (.ref_clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .motion_in_progress, .step_dir, .step_count);

// >>> rzh_drive_model.sv
`timescale 1ns/1ns
module rzh_drive_model #(
    parameter int SPAN = 1000
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        step_dir,
    input  wire logic [31:0] step_count,
    output logic             home_sensor,
    output logic             limit_sensor_pos,
    output logic             limit_sensor_neg
);
    logic signed [31:0] axis_pos;
    // The physical axis follows the steps only, not writes to the position register.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            axis_pos <= 32'sh0;
        end else begin
            axis_pos <= step_dir ? axis_pos + $signed(step_count)
                                 : axis_pos - $signed(step_count);
        end
    end
    assign home_sensor      = axis_pos >= -32'sd4 && axis_pos <= 32'sd4;
    assign limit_sensor_pos = axis_pos >= SPAN;
    assign limit_sensor_neg = axis_pos <= -SPAN;
endmodule

// >>> rzh_top_test.sv
`timescale 1ns/1ns
module rzh_top_test
    import rzh_pkg::*;
;
    logic        ref_clk, reset, avs_read, avs_write, avs_waitrequest, step_dir;
    logic        home_sensor, limit_sensor_pos, limit_sensor_neg, motion_in_progress;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, step_count, rd, peak;
    int          bad_count, checks;
    rzh_top i_rzh_top (.ref_clk, .reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
        .home_sensor, .limit_sensor_pos, .limit_sensor_neg, .motion_in_progress,
        .step_dir, .step_count);
    rzh_drive_model i_rzh_drive_model (.ref_clk, .reset, .step_dir, .step_count,
        .home_sensor, .limit_sensor_pos, .limit_sensor_neg);
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (bad_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic timeout();
        chk("wait bound", 32'h0, 32'h1);
        tally_and_finish();
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic busy;
        int   n;
        @(posedge ref_clk);
        {avs_read, avs_write, avs_address, avs_writedata} <= {!w, w, a, d};
        n = 0;
        do begin
            @(negedge ref_clk);
            busy = avs_waitrequest;
            rd = avs_readdata;
            @(posedge ref_clk);
            n++;
            if (n > 50) timeout();
        end while (busy !== 1'b0);
        {avs_read, avs_write} <= 2'b00;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string s);
        bus(1'b0, a, 32'h0);
        chk(s, e, rd & m);
    endtask
    task automatic cmd(input logic [3:0] c);
        bus(1'b1, REG_CMD, {28'h0, c});
    endtask
    task automatic settle();
        int n;
        peak = 32'h0;
        n = 0;
        do begin
            @(negedge ref_clk);
            if (step_count > peak) peak = step_count;
            n++;
            if (n > 3000) timeout();
        end while (motion_in_progress !== 1'b0);
    endtask
    task automatic rst();
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_limits();
        rchk(REG_RUN_SPD, 32'hffff_ffff, RST_RUN_SPD, "run speed");
        rchk(8'hfc, 32'hffff_ffff, 32'h0, "unmapped");
        bus(1'b1, REG_LIMIT_POS, 32'h32);
        bus(1'b1, REG_LIMIT_NEG, 32'hffff_ffce);
        bus(1'b1, REG_CONTROL, 32'h7);
        rchk(REG_STATUS, 32'h6, 32'h0, "check without home");
        bus(1'b1, REG_TARGET, 32'h64);
        cmd(CMD_ABS_GOTO);
        settle();
        rchk(REG_POSITION, 32'hffff_ffff, 32'h64, "unchecked move");
        cmd(CMD_SEEK_NEG);
        settle();
        rchk(REG_STATUS, 32'h6, 32'h6, "home and check");
        rchk(REG_POSITION, 32'hffff_ffff, 32'h0, "seek end");
        cmd(CMD_ABS_GOTO);
        settle();
        rchk(REG_STATUS, 32'h8, 32'h8, "over limit");
        bus(1'b0, REG_POSITION, 32'h0);
        chk("limited stop", 32'h1, {31'h0, rd != 32'h64 && $signed(rd) >= 50});
        bus(1'b1, REG_CONTROL, 32'h6);
        rchk(REG_STATUS, 32'h4, 32'h0, "check disabled");
    endtask
    task automatic s_return_zero();
        bus(1'b1, REG_RUN_SPD, 32'h3);
        bus(1'b1, REG_ACCEL, 32'h2);
        bus(1'b1, REG_DECEL, 32'h2);
        bus(1'b1, REG_POSITION, 32'hc8);
        cmd(CMD_RETURN_ZERO);
        rchk(REG_STATUS, 32'h1, 32'h1, "moving after ack");
        settle();
        chk("peak speed", 32'h3, peak);
        rchk(REG_POSITION, 32'hffff_ffff, 32'h0, "at zero");
        rchk(REG_STATUS, 32'h83, 32'h82, "home from zero");
    endtask
    task automatic s_reject();
        bus(1'b1, REG_TARGET, 32'h64);
        cmd(CMD_ABS_GOTO);
        cmd(CMD_RETURN_ZERO);
        bus(1'b1, REG_TARGET, 32'h28);
        cmd(CMD_ABS_GOTO);
        rchk(REG_TARGET, 32'hffff_ffff, 32'h28, "target in move");
        rchk(REG_STATUS, 32'h20, 32'h20, "rejected");
        settle();
        rchk(REG_POSITION, 32'hffff_ffff, 32'h64, "refused moves");
        cmd(CMD_NONE);
        rchk(REG_STATUS, 32'h20, 32'h0, "reject cleared");
    endtask
    task automatic s_branch(input logic c, input logic [31:0] e);
        bus(1'b1, REG_COND, {31'h0, c});
        bus(1'b1, REG_TARGET, 32'h1e);
        cmd(CMD_IF);
        cmd(CMD_ELSE);
        cmd(CMD_ABS_GOTO);
        rchk(REG_STATUS, 32'h40, c ? 32'h0 : 32'h40, "else taken");
        cmd(CMD_ENDIF);
        settle();
        rchk(REG_POSITION, 32'hffff_ffff, e, "else block");
    endtask
    task automatic s_stop();
        bus(1'b1, REG_TARGET, 32'h64);
        cmd(CMD_ABS_GOTO);
        cmd(CMD_STOP);
        rchk(REG_STATUS, 32'h81, 32'h80, "stopped");
        bus(1'b0, REG_POSITION, 32'h0);
        chk("stop short", 32'h1, {31'h0, $signed(rd) < 32'sh64});
    endtask
    initial begin
        reset = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = 42'h0;
        bad_count = 0;
        checks = 0;
        rst();
        s_limits();
        rst();
        s_return_zero();
        s_reject();
        s_branch(1'b1, 32'h64);
        s_branch(1'b0, 32'h1e);
        s_stop();
        tally_and_finish();
    end
endmodule
